// *** rtl/sse_pkg.sv ***
package sse_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NEAR_BAND = 8'h04;
  localparam logic [7:0] REG_HOME_SPEED = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ALARM_CODE = 8'h10;
  // CTRL fields
  localparam int CTRL_HOME_EN = 0;
  localparam int CTRL_FAULT_CLR = 1;
  localparam int CTRL_ALARM_CLR = 2;
  localparam logic CTRL_HOME_EN_RST = 1'b1;
  // STATUS fields
  localparam int ST_ORIENT = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_MOTOR_FAIL = 3;
  localparam int ST_SINK_FAIL = 4;
  localparam int ST_PANEL_FAIL = 5;
  localparam int ST_ARMED = 6;
  localparam int ST_CODE_LSB = 8;
  // Reset values
  localparam logic [15:0] NEAR_BAND_RST = 16'h0010;
  localparam logic [15:0] HOME_SPEED_RPM = 16'h03E8;
  localparam logic [7:0] PANEL_LIMIT_C = 8'h3C;
  // Thermal codes, warning then failure
  localparam logic [11:0] CODE_NONE = 12'h000;
  localparam logic [11:0] CODE_MOTOR_WARN = 12'h384;
  localparam logic [11:0] CODE_MOTOR_FAIL = 12'h385;
  localparam logic [11:0] CODE_SINK_WARN = 12'h387;
  localparam logic [11:0] CODE_SINK_FAIL = 12'h388;
  localparam logic [11:0] CODE_PANEL_WARN = 12'h38A;
  localparam logic [11:0] CODE_PANEL_FAIL = 12'h38B;
  // Timing
  localparam logic [63:0] CLK_HZ = 64'd50_000_000;
  localparam logic [63:0] OVERHEAT_TIME_S = 64'd60;
  localparam logic [63:0] OVERHEAT_CYCLES = OVERHEAT_TIME_S * CLK_HZ;
  localparam logic [31:0] OVERHEAT_CYC_DEF = OVERHEAT_CYCLES[31:0];
endpackage

// *** rtl/sse_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module sse_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous in, filtered out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // Refused at elaboration so a bad width never reaches a netlist
  if (W < 1) begin : g_bad_width
    $error("sse_sync width must be at least one");
  end

  // A bit moves only once the second and third stages agree
  always_comb begin
    next_q = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule // sse_sync
`default_nettype wire

// *** rtl/sse_status_enc.sv ***
//
// Function
// - After an orientation request, close orient_done when error is inside band.
// - While orient_done is closed, hold torque against outside force.
// - Open orient_done again when error leaves the near band.
// - One home pulse per spindle revolution from the magnetic sensor.
// - Home pulses only at or below the speed threshold, 1000 r/min.
// - Overcurrent or overload trip cuts current and asserts fault output.
// - Fault relay closes during protection; both NO and NC contacts.
// - Active protective function shown as four-bit code on four outputs.
// - Any overtemperature raises the alarm output while running on.
// - Motor overheat for one minute escalates to failure and cuts current.
// - Heatsink overheat for one minute escalates to failure and cuts current.
// - Panel temperature above 60 C escalates to failure and cuts current.
// - Light faults of options also raise the alarm output.
// - Repeat encoder phases A, B and C at encoder resolution.
// - A and B stay a quadrature pair a quarter cycle apart.
// - Phase C carries the once-per-revolution index pulse.
// - Each phase driven as true output plus its complement.
`timescale 1ns/1ns
`default_nettype none
module sse_status_enc #(
  parameter logic [31:0] OVERHEAT_CYC = sse_pkg::OVERHEAT_CYC_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside
  input wire logic orient_request,
  input wire logic mag_sensor,
  input wire logic enc_in_a,
  input wire logic enc_in_b,
  input wire logic enc_in_index,
  // Control core detections
  input wire logic signed [15:0] position_error,
  input wire logic [15:0] spindle_speed,
  input wire logic overcurrent_trip,
  input wire logic overload_trip,
  input wire logic [3:0] prot_code_in,
  input wire logic motor_hot,
  input wire logic heatsink_hot,
  input wire logic panel_warm,
  input wire logic [7:0] panel_temp_c,
  input wire logic option_light_fault,
  // Status outputs
  output logic orient_done,
  output logic holding_torque_en,
  output logic spindle_home_pulse,
  output logic current_cut,
  output logic fault_contact_no,
  output logic fault_contact_nc,
  output logic fault_display_indication,
  output logic prot_code_bit0,
  output logic prot_code_bit1,
  output logic prot_code_bit2,
  output logic prot_code_bit3,
  output logic thermal_alarm,
  // Encoder repeater
  output logic enc_out_a,
  output logic enc_out_a_n,
  output logic enc_out_b,
  output logic enc_out_b_n,
  output logic enc_out_index,
  output logic enc_out_index_n
);
  import sse_pkg::*;

  if (OVERHEAT_CYC < 32'd2) begin : g_bad_cyc
    $error("OVERHEAT_CYC must be at least 2");
  end

  // Synchronised pins
  logic [4:0] pins_s;
  logic req_s;
  logic mag_s;
  logic a_s;
  logic b_s;
  logic z_s;

  sse_sync #(.W(5)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({orient_request, mag_sensor, enc_in_a, enc_in_b, enc_in_index}),
    .q(pins_s)
  );
  assign {req_s, mag_s, a_s, b_s, z_s} = pins_s;

  // APB register group
  logic home_en;
  logic [15:0] near_band;
  logic [15:0] home_speed;
  logic fault_clr;
  logic alarm_clr;
  logic next_home_en;
  logic [15:0] next_near_band;
  logic [15:0] next_home_speed;
  logic next_fault_clr;
  logic next_alarm_clr;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_en;
  logic [31:0] status_word;
  logic [11:0] alarm_code;

  assign wr_en = psel & penable & pready & pwrite;

  // Read data is fetched in the setup cycle so pready can be a flop
  always_comb begin
    next_home_en = home_en;
    next_near_band = near_band;
    next_home_speed = home_speed;
    next_fault_clr = 1'b0;
    next_alarm_clr = 1'b0;
    next_pready = psel & ~penable;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_pslverr = 1'b0;
      case (paddr)
        REG_CTRL: next_prdata = {31'h0, home_en};
        REG_NEAR_BAND: next_prdata = {16'h0, near_band};
        REG_HOME_SPEED: next_prdata = {16'h0, home_speed};
        REG_STATUS: next_prdata = status_word;
        REG_ALARM_CODE: next_prdata = {20'h0, alarm_code};
        default: begin
          next_prdata = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (wr_en) begin
      case (paddr)
        REG_CTRL: begin
          next_home_en = pwdata[CTRL_HOME_EN];
          next_fault_clr = pwdata[CTRL_FAULT_CLR];
          next_alarm_clr = pwdata[CTRL_ALARM_CLR];
        end
        REG_NEAR_BAND: next_near_band = pwdata[15:0];
        REG_HOME_SPEED: next_home_speed = pwdata[15:0];
        default: next_home_en = home_en;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      home_en <= CTRL_HOME_EN_RST;
      near_band <= NEAR_BAND_RST;
      home_speed <= HOME_SPEED_RPM;
      fault_clr <= 1'b0;
      alarm_clr <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      home_en <= next_home_en;
      near_band <= next_near_band;
      home_speed <= next_home_speed;
      fault_clr <= next_fault_clr;
      alarm_clr <= next_alarm_clr;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Orientation group
  logic armed;
  logic next_armed;
  logic next_orient_done;
  logic [15:0] err_abs;
  logic in_band;

  assign err_abs = position_error[15] ? 16'(-position_error) :
                   16'(position_error);
  assign in_band = err_abs <= near_band;

  always_comb begin
    next_armed = req_s;
    next_orient_done = req_s & armed & in_band;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      orient_done <= 1'b0;
      holding_torque_en <= 1'b0;
    end else begin
      armed <= next_armed;
      orient_done <= next_orient_done;
      holding_torque_en <= next_orient_done;
    end
  end

  // Home pulse group; rising sensor edge only, so one per turn
  logic mag_d;
  logic next_home;

  always_comb begin
    next_home = mag_s & ~mag_d & home_en & (spindle_speed <= home_speed);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mag_d <= 1'b0;
      spindle_home_pulse <= 1'b0;
    end else begin
      mag_d <= mag_s;
      spindle_home_pulse <= next_home;
    end
  end

  // Overheat timers, motor and heatsink
  logic [1:0] hot;
  logic [1:0] fail;
  logic [31:0] tcnt [2];
  assign hot = {heatsink_hot, motor_hot};

  for (genvar i = 0; i < 2; i++) begin : g_timer
    logic [31:0] next_cnt;
    logic next_fail;
    logic at_limit;
    assign at_limit = tcnt[i] == OVERHEAT_CYC - 32'd1;
    // Set wins over a software clear while the heat persists
    always_comb begin
      next_cnt = hot[i] ? (at_limit ? tcnt[i] : tcnt[i] + 32'd1) : 32'h0;
      next_fail = (hot[i] & at_limit) | (fail[i] & ~alarm_clr);
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tcnt[i] <= 32'h0;
        fail[i] <= 1'b0;
      end else begin
        tcnt[i] <= next_cnt;
        fail[i] <= next_fail;
      end
    end
  end

  // Alarm and fault group
  logic panel_fail;
  logic fault;
  logic [3:0] code_hold;
  logic next_panel_fail;
  logic next_fault;
  logic [3:0] next_code;
  logic next_alarm;
  logic trip;
  logic warn;

  assign warn = motor_hot | heatsink_hot | panel_warm | option_light_fault;
  assign trip = overcurrent_trip | overload_trip | (|fail) | panel_fail;

  always_comb begin
    next_panel_fail = (panel_temp_c > PANEL_LIMIT_C) |
                      (panel_fail & ~alarm_clr);
    next_fault = trip | (fault & ~fault_clr);
    // Code is caught at the start of a fault and frozen while it lasts
    next_code = (trip && !fault) ? prot_code_in : code_hold;
    next_alarm = warn | trip;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_fail <= 1'b0;
      fault <= 1'b0;
      code_hold <= 4'h0;
      thermal_alarm <= 1'b0;
      current_cut <= 1'b0;
      fault_contact_no <= 1'b0;
      fault_contact_nc <= 1'b1;
      fault_display_indication <= 1'b0;
      {prot_code_bit3, prot_code_bit2, prot_code_bit1, prot_code_bit0} <= 4'h0;
    end else begin
      panel_fail <= next_panel_fail;
      fault <= next_fault;
      code_hold <= next_code;
      thermal_alarm <= next_alarm;
      current_cut <= next_fault;
      fault_contact_no <= next_fault;
      fault_contact_nc <= ~next_fault;
      fault_display_indication <= next_fault;
      {prot_code_bit3, prot_code_bit2, prot_code_bit1, prot_code_bit0} <=
        next_code;
    end
  end

  always_comb begin
    if (fail[0]) alarm_code = CODE_MOTOR_FAIL;
    else if (fail[1]) alarm_code = CODE_SINK_FAIL;
    else if (panel_fail) alarm_code = CODE_PANEL_FAIL;
    else if (motor_hot) alarm_code = CODE_MOTOR_WARN;
    else if (heatsink_hot) alarm_code = CODE_SINK_WARN;
    else if (panel_warm) alarm_code = CODE_PANEL_WARN;
    else alarm_code = CODE_NONE;
  end

  always_comb begin
    status_word = 32'h0;
    status_word[ST_ORIENT] = orient_done;
    status_word[ST_FAULT] = fault;
    status_word[ST_ALARM] = thermal_alarm;
    status_word[ST_MOTOR_FAIL] = fail[0];
    status_word[ST_SINK_FAIL] = fail[1];
    status_word[ST_PANEL_FAIL] = panel_fail;
    status_word[ST_ARMED] = armed;
    status_word[ST_CODE_LSB +: 4] = code_hold;
  end

  // Encoder repeater; one flop stage keeps the A/B lead intact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_out_a <= 1'b0;
      enc_out_a_n <= 1'b1;
      enc_out_b <= 1'b0;
      enc_out_b_n <= 1'b1;
      enc_out_index <= 1'b0;
      enc_out_index_n <= 1'b1;
    end else begin
      enc_out_a <= a_s;
      enc_out_a_n <= ~a_s;
      enc_out_b <= b_s;
      enc_out_b_n <= ~b_s;
      enc_out_index <= z_s;
      enc_out_index_n <= ~z_s;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_req_in_band;
    req_s && armed && in_band;
  endsequence

  a_orient_close: assert property ($rose(orient_done) |-> $past(req_s && armed && in_band))
    else $error("orient_done closed without request in band");
  a_orient_when: assert property (s_req_in_band |=> orient_done)
    else $error("orient_done missed band entry");
  a_hold_torque: assert property (orient_done |-> holding_torque_en)
    else $error("no holding torque while orient_done");
  a_orient_open: assert property (orient_done && !in_band |=> !orient_done)
    else $error("orient_done stayed closed outside band");
  a_home_single: assert property (spindle_home_pulse |=> !spindle_home_pulse)
    else $error("home pulse longer than one cycle");
  a_home_gate: assert property (spindle_home_pulse |-> $past(spindle_speed <= home_speed))
    else $error("home pulse above speed threshold");
  a_fault_cut: assert property ((overcurrent_trip || overload_trip) |=> current_cut && fault_contact_no)
    else $error("trip did not cut current");
  a_contact_pair: assert property (fault_contact_no != fault_contact_nc)
    else $error("fault contacts not complementary");
  a_code_hold: assert property (fault_contact_no ##1 fault_contact_no |->
      $stable({prot_code_bit3, prot_code_bit2, prot_code_bit1,
      prot_code_bit0}))
    else $error("protective code moved during fault");
  a_alarm_warn: assert property (warn |=> thermal_alarm)
    else $error("warning not shown on alarm");
  a_motor_escalate: assert property ($rose(fail[0]) |-> $past(tcnt[0]) == OVERHEAT_CYC - 32'd1)
    else $error("motor failure before full overheat time");
  a_sink_escalate: assert property ($rose(fail[1]) |-> $past(tcnt[1]) == OVERHEAT_CYC - 32'd1)
    else $error("heatsink failure before full overheat time");
  a_panel_fail: assert property (panel_temp_c > PANEL_LIMIT_C |=> panel_fail ##1 current_cut)
    else $error("panel overtemperature not escalated");
  a_enc_follow: assert property (enc_out_a == $past(a_s) && enc_out_b == $past(b_s))
    else $error("encoder phases not repeated");
  a_enc_pairs: assert property ((enc_out_a ^ enc_out_a_n) &&
      (enc_out_b ^ enc_out_b_n) && (enc_out_index ^ enc_out_index_n))
    else $error("encoder line pair not complementary");
endmodule // sse_status_enc
`default_nettype wire

// *** tb/sse_far_side.sv ***
`timescale 1ns/1ns
`default_nettype none
module sse_far_side (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequence controller
  input wire logic want_orient,
  input wire logic want_run,
  input wire logic orient_done,
  input wire logic fault_contact_no,
  output logic orient_request,
  output logic tool_change_ok,
  output logic run_forward_cmd,
  output logic fail_warn,
  output logic orient_fail,
  // Line receivers
  input wire logic enc_out_a,
  input wire logic enc_out_a_n,
  input wire logic enc_out_b,
  input wire logic enc_out_b_n,
  input wire logic enc_out_index,
  input wire logic enc_out_index_n,
  output logic signed [15:0] pos,
  output logic [7:0] index_cnt,
  output logic line_err
);
  logic pa, pb, pc, pd;
  assign orient_request = want_orient;
  // Tools may only be changed while the spindle is held
  assign tool_change_ok = orient_done;
  assign run_forward_cmd = want_run & ~fault_contact_no;
  assign fail_warn = fault_contact_no;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pa, pb, pc, pd, orient_fail, line_err} <= 6'h00;
      pos <= 16'sh0000;
      index_cnt <= 8'h00;
    end else begin
      pa <= enc_out_a;
      pb <= enc_out_b;
      pc <= enc_out_index;
      pd <= orient_done;
      // Losing the hold during a request counts as a failed orientation
      if (want_orient && pd && !orient_done) begin
        orient_fail <= 1'b1;
      end
      // A leading B counts up, so direction must survive the repeater
      if ({enc_out_a, enc_out_b} != {pa, pb}) begin
        pos <= (pa ^ enc_out_b) ? pos - 16'sh0001 : pos + 16'sh0001;
      end
      if (enc_out_index && !pc) begin
        index_cnt <= index_cnt + 8'h01;
      end
      if ((enc_out_a == enc_out_a_n) || (enc_out_b == enc_out_b_n) ||
          (enc_out_index == enc_out_index_n)) begin
        line_err <= 1'b1;
      end
    end
  end
endmodule // sse_far_side
`default_nettype wire

// *** tb/spindle_status_and_encoder_output_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module spindle_status_and_encoder_output_tb;
  import sse_pkg::*;
  // Short overheat time keeps the run small
  localparam logic [31:0] OVC = 32'h0000_0014;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, panel_temp_c, index_cnt, home_cnt, h;
  logic [31:0] pwdata, prdata, rd, hot_cyc, wv;
  logic want_orient, want_run, orient_request, mag_sensor;
  logic enc_in_a, enc_in_b, enc_in_index, overcurrent_trip, overload_trip;
  logic motor_hot, heatsink_hot, panel_warm, option_light_fault;
  logic signed [15:0] position_error, pos, exp_pos;
  logic [15:0] spindle_speed;
  logic [3:0] prot_code_in, code, pcode;
  logic [1:0] ph;
  logic orient_done, holding_torque_en, spindle_home_pulse, current_cut;
  logic fault_contact_no, fault_contact_nc, fault_display_indication;
  logic thermal_alarm, enc_out_a, enc_out_a_n, enc_out_b, enc_out_b_n;
  logic enc_out_index, enc_out_index_n;
  logic tool_change_ok, run_forward_cmd, fail_warn, orient_fail, line_err;
  int num_errors, checked, seed, n;

  sse_status_enc #(.OVERHEAT_CYC(OVC)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .orient_request, .mag_sensor, .enc_in_a, .enc_in_b, .enc_in_index,
    .position_error, .spindle_speed, .overcurrent_trip, .overload_trip,
    .prot_code_in, .motor_hot, .heatsink_hot, .panel_warm, .panel_temp_c,
    .option_light_fault, .orient_done, .holding_torque_en,
    .spindle_home_pulse, .current_cut, .fault_contact_no, .fault_contact_nc,
    .fault_display_indication, .prot_code_bit0(pcode[0]),
    .prot_code_bit1(pcode[1]), .prot_code_bit2(pcode[2]),
    .prot_code_bit3(pcode[3]), .thermal_alarm, .enc_out_a, .enc_out_a_n,
    .enc_out_b, .enc_out_b_n, .enc_out_index, .enc_out_index_n);

  sse_far_side u_far (.pclk, .presetn, .want_orient, .want_run, .orient_done,
    .fault_contact_no, .orient_request, .tool_change_ok, .run_forward_cmd,
    .fail_warn, .orient_fail, .enc_out_a, .enc_out_a_n, .enc_out_b,
    .enc_out_b_n, .enc_out_index, .enc_out_index_n, .pos, .index_cnt,
    .line_err);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      home_cnt <= 8'h00;
      hot_cyc <= 32'h0;
    end else begin
      home_cnt <= home_cnt + 8'(spindle_home_pulse === 1'b1);
      hot_cyc <= (motor_hot | heatsink_hot) ? hot_cyc + 32'h1 : 32'h0;
    end
  end

  // Phase A leads B when the step count rises
  function automatic logic [1:0] quad(input logic [1:0] p);
    return {^p, p[1]};
  endfunction

  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int w;
    w = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never rewrites psel in this step
    @(posedge pclk);
  endtask

  initial begin
    seed = 8730;
    presetn = 1'b0;
    {psel, penable, pwrite, want_orient, want_run, mag_sensor} = '0;
    {enc_in_a, enc_in_b, enc_in_index, overcurrent_trip, overload_trip} = '0;
    {motor_hot, heatsink_hot, panel_warm, option_light_fault} = '0;
    {paddr, pwdata, position_error, spindle_speed, prot_code_in} = '0;
    {exp_pos, ph, num_errors, checked} = '0;
    panel_temp_c = 8'h14;
    cyc(16);
    presetn <= 1'b1;
    chk({fault_contact_nc, enc_out_a_n, orient_done, current_cut}, 4'hC);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, REG_NEAR_BAND, 32'h0);
    chk(rd, 32'h0000_0010);
    apb(1'b0, REG_HOME_SPEED, 32'h0);
    chk(rd, 32'h0000_03E8);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    wv = 32'($random(seed)) & 32'h0000_FFFF;
    apb(1'b1, REG_NEAR_BAND, wv);
    apb(1'b0, REG_NEAR_BAND, 32'h0);
    chk(rd, wv);
    apb(1'b1, REG_NEAR_BAND, 32'h0000_0010);
    $display("test reset done");
    // Error just outside, then on the edge of, the near band
    position_error <= 16'sd17;
    want_orient <= 1'b1;
    cyc(8);
    chk(orient_done, 1'b0);
    position_error <= -16'sd16;
    cyc(8);
    chk({orient_done, holding_torque_en, tool_change_ok}, 3'h7);
    position_error <= 16'sd17 + 16'($random(seed) & 32'hFF);
    cyc(8);
    chk({orient_done, holding_torque_en, orient_fail}, 3'h1);
    want_orient <= 1'b0;
    $display("test orientation done");
    for (int s = 0; s < 3; s++) begin
      spindle_speed <= (s == 1) ? 16'h03E9 : 16'h03E8;
      // Last round runs slow with home pulses switched off
      if (s == 2) begin
        apb(1'b1, REG_CTRL, 32'h0000_0000);
      end
      h = home_cnt;
      repeat (3) begin
        mag_sensor <= 1'b1;
        cyc(6);
        mag_sensor <= 1'b0;
        cyc(6);
      end
      chk(home_cnt - h, (s == 0) ? 8'h03 : 8'h00);
    end
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    $display("test home pulse done");
    want_run <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      code = 4'($random(seed));
      prot_code_in <= code;
      overload_trip <= (t == 0);
      overcurrent_trip <= (t == 1);
      cyc(2);
      chk({current_cut, fault_contact_no, fault_contact_nc, pcode},
          {3'b110, code});
      prot_code_in <= ~code;
      // Clearing while the trip is still present must be refused
      apb(1'b1, REG_CTRL, 32'h0000_0003);
      cyc(8);
      chk({pcode, fault_display_indication, fail_warn, run_forward_cmd},
          {code, 3'b110});
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd, {20'h0, code, 8'h06});
      {overload_trip, overcurrent_trip} <= 2'b00;
      apb(1'b1, REG_CTRL, 32'h0000_0003);
      cyc(3);
      chk({current_cut, fault_contact_no, run_forward_cmd}, 3'b001);
    end
    $display("test fault done");
    for (int i = 0; i < 3; i++) begin
      {panel_warm, heatsink_hot, motor_hot} <= 3'(1 << i);
      cyc(4);
      chk({thermal_alarm, current_cut}, 2'b10);
      apb(1'b0, REG_ALARM_CODE, 32'h0);
      chk(rd, 32'h384 + 32'(3 * i));
      if (i == 2) begin
        panel_temp_c <= 8'h3C;
        cyc(30);
        chk(current_cut, 1'b0);
        panel_temp_c <= 8'h3D;
      end
      n = 0;
      while (current_cut !== 1'b1 && n < 60) begin
        @(posedge pclk);
        n++;
      end
      chk(current_cut, 1'b1);
      if (i < 2) begin
        chk(hot_cyc >= OVC && hot_cyc <= OVC + 32'h4, 1'b1);
      end
      apb(1'b0, REG_ALARM_CODE, 32'h0);
      chk(rd, 32'h385 + 32'(3 * i));
      {panel_warm, heatsink_hot, motor_hot} <= 3'b000;
      panel_temp_c <= 8'h14;
      apb(1'b1, REG_CTRL, 32'h0000_0005);
      apb(1'b1, REG_CTRL, 32'h0000_0003);
      cyc(3);
      chk({thermal_alarm, current_cut}, 2'b00);
    end
    option_light_fault <= 1'b1;
    cyc(3);
    chk({thermal_alarm, current_cut}, 2'b10);
    option_light_fault <= 1'b0;
    $display("test thermal done");
    for (int k = 0; k < 40; k++) begin
      if ($random(seed) & 1) begin
        ph = ph + 2'h1;
        exp_pos = exp_pos + 16'sh0001;
      end else begin
        ph = ph - 2'h1;
        exp_pos = exp_pos - 16'sh0001;
      end
      {enc_in_a, enc_in_b} <= quad(ph);
      enc_in_index <= (k == 20);
      cyc(6);
    end
    // Receiver counts the last step one edge after the repeater shows it
    cyc(2);
    chk(pos, exp_pos);
    chk({index_cnt, line_err}, 9'h002);
    chk({enc_out_a ^ enc_out_a_n, enc_out_b ^ enc_out_b_n}, 2'h3);
    $display("test encoder done");
    results();
  end
endmodule // spindle_status_and_encoder_output_tb
`default_nettype wire
